// *** core/bss_pkg.sv ***
/*
 * Constants, register map and state codes of the boot and status signalling block.
 * Assumes a single 50 MHz system clock; all times are turned into cycle counts here.
 */
package bss_pkg;

    // ------------------------------------------------------------------
    // Clock and time conversion
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 20;

    // Least times round up, never below one cycle
    function automatic int unsigned bss_cycles_ceil(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : bss_cycles_ceil

    // Longest times round down, never below one cycle
    function automatic int unsigned bss_cycles_floor(input int unsigned ns);
        int unsigned c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : bss_cycles_floor

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned INIT_TIME_NS      = 100_000;
    localparam int unsigned INIT_CYCLES_DEF   = bss_cycles_ceil(INIT_TIME_NS);
    localparam int unsigned ALIVE_HALF_NS     = 500_000_000;
    localparam int unsigned ALIVE_HALF_DEF    = bss_cycles_floor(ALIVE_HALF_NS);
    localparam int unsigned AUX_PULSE_NS      = 200;
    localparam logic [3:0]  AUX_PULSE_LEN     = 4'(bss_cycles_ceil(AUX_PULSE_NS));
    localparam int unsigned LOOP_TIMEOUT_NS   = 1_000;
    localparam logic [7:0]  LOOP_LAST         = 8'(bss_cycles_floor(LOOP_TIMEOUT_NS) - 1);
    localparam logic [1:0]  SYNC_FILL         = 2'h2;
    localparam int unsigned CNT_W             = 26;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_STATE    = 8'h04;
    localparam logic [7:0]  REG_PULSE    = 8'h08;
    localparam logic [7:0]  REG_IRQ_STAT = 8'h0C;
    localparam logic [7:0]  REG_IRQ_MASK = 8'h10;

    localparam int unsigned CTRL_SPLIT   = 0;
    localparam int unsigned CTRL_HALT    = 1;
    localparam int unsigned CTRL_FHOLD   = 2;
    localparam int unsigned CTRL_FFORCE  = 3;
    localparam logic [3:0]  CTRL_RESET   = 4'h1;

    localparam int unsigned ST_BOOTLOAD  = 0;
    localparam int unsigned ST_INITDONE  = 1;
    localparam int unsigned ST_OPER      = 2;
    localparam int unsigned ST_FAULT     = 3;
    localparam int unsigned ST_STRAP     = 4;
    localparam int unsigned ST_WAIT      = 5;

    localparam int unsigned IRQ_SEQ      = 0;
    localparam int unsigned IRQ_LOOP     = 2;
    localparam int unsigned IRQ_INIT     = 4;
    localparam logic [4:0]  MASK_RESET   = 5'h00;

    // ------------------------------------------------------------------
    // Sequence states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_SAMPLE = 4'b0001,
        PH_INIT   = 4'b0010,
        PH_RUN    = 4'b0100,
        PH_BOOT   = 4'b1000
    } bss_phase_t;

endpackage : bss_pkg

// *** core/bss_boot_status.sv ***
/*
 * Boot and status signalling block: boot strap capture, start-up sequence,
 * USB buffer enable, fault and liveness pins, sequencer loopback and a small
 * register port with interrupt.
 * Offsets: 0x00 control, 0x04 state,
 * 0x08 pulse, 0x0C status, 0x10 mask.
 * Status is sticky, cleared by writing ones.
 * Reads answer one cycle after the strobe.
 * Fault: lost loop pulse or forced by software,
 * held or blinking on the liveness timebase.
 * Aux pulses are refused until running.
 * Assumes pins arrive asynchronously, the strap settles before reset release
 * and the board ties each sequencer aux output to its interrupt input.
 */
// Design decisions made here: the address map and the address-and-strobe port.
// Operation
// - Strap low at start-up selects bootload mode
// - Strap high at start-up selects normal mode
// - USB buffer enabled only after initialization
// - Fault shown by toggling or holding high
// - Liveness pin toggles about once per half second
// - Aux output A returns on irq input A
// - Aux output B returns on irq input B
// - Split configuration output high after reset
`timescale 1ns/1ps

module bss_boot_status #(
    parameter int unsigned INIT_CYCLES = bss_pkg::INIT_CYCLES_DEF,
    parameter int unsigned ALIVE_HALF  = bss_pkg::ALIVE_HALF_DEF
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        boot_select_n,
    input  wire logic        sequencer_irq_in_a,
    input  wire logic        sequencer_irq_in_b,
    output logic             usb_buffer_enable_n,
    output logic             fault_status,
    output logic             alive_toggle,
    output logic             sequencer_aux_out_a,
    output logic             sequencer_aux_out_b,
    output logic             split_config_out,
    output logic             bootload_mode,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdata,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Derived limits
    // ------------------------------------------------------------------
    localparam logic [bss_pkg::CNT_W-1:0] INIT_LAST  = bss_pkg::CNT_W'(INIT_CYCLES - 1);
    localparam logic [bss_pkg::CNT_W-1:0] ALIVE_LAST = bss_pkg::CNT_W'(ALIVE_HALF - 1);
    // Counters reach one short of the count; init holds there, liveness wraps

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        // Start-up sequence
        bss_pkg::bss_phase_t           phase;

        // Pin synchronisers
        logic                          bootSync1;
        logic                          bootSync2;
        logic [1:0]                    seqSync1;
        logic [1:0]                    seqSync2;
        logic [1:0]                    seqPrev;

        // Strap capture
        logic [1:0]                    syncCnt;
        logic                          strapLevel;
        logic                          bootload;

        // Timebases
        logic [bss_pkg::CNT_W-1:0]     initCnt;
        logic [bss_pkg::CNT_W-1:0]     aliveCnt;

        // Pin levels
        logic                          alive;
        logic                          fault;
        logic                          usbEnN;

        // Software registers
        logic [3:0]                    ctrl;
        logic [4:0]                    irqStat;
        logic [4:0]                    irqMask;

        // Loopback channels
        logic [1:0][3:0]               pulseCnt;
        logic [1:0]                    auxOut;
        logic [1:0]                    loopWait;
        logic [1:0][7:0]               loopCnt;

        // Bus answer and interrupt
        logic [31:0]                   rdata;
        logic                          irqOut;
    } bss_regs_t;

    // Split configuration starts high and the USB buffer starts disabled
    // Phase starts in PH_SAMPLE; all other state clears
    localparam bss_regs_t RESET_VAL = '{
        phase:   bss_pkg::PH_SAMPLE,
        ctrl:    bss_pkg::CTRL_RESET,
        usbEnN:  1'b1,
        irqMask: bss_pkg::MASK_RESET,
        default: '0
    };

    bss_regs_t r_ff;
    bss_regs_t nxt_r;

    // Start-up after reset release:
    //   edges 1-2: synchroniser fills
    //   edge 3: strap taken once
    //   init end: buffer opens
    // Pulse, from write edge c0:
    //   c1: aux high, wait starts
    //   c4: return edge seen
    //   c11: aux low again
    // A late return is a loop fault.

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        // Helpers cleared first, no latches
        logic [1:0] seqRise;
        logic [4:0] evt;
        logic [4:0] clr;
        logic       running;
        logic       oper;
        logic       faultOn;
        logic       aliveWrap;

        seqRise   = '0;
        evt       = '0;
        clr       = '0;
        running   = 1'b0;
        oper      = 1'b0;
        faultOn   = 1'b0;
        aliveWrap = 1'b0;
        nxt_r     = r_ff;

        // Two-stage synchronisers; only the second stage feeds logic
        nxt_r.bootSync1 = boot_select_n;
        nxt_r.bootSync2 = r_ff.bootSync1;
        nxt_r.seqSync1  = {sequencer_irq_in_b, sequencer_irq_in_a};
        nxt_r.seqSync2  = r_ff.seqSync1;
        nxt_r.seqPrev   = r_ff.seqSync2;
        seqRise         = r_ff.seqSync2 & ~r_ff.seqPrev;

        // Start-up sequence
        unique case (r_ff.phase)
            bss_pkg::PH_SAMPLE: begin
                // Wait until the synchroniser holds the settled strap, then take it once
                if (r_ff.syncCnt == bss_pkg::SYNC_FILL) begin
                    nxt_r.strapLevel = r_ff.bootSync2;
                    nxt_r.bootload   = ~r_ff.bootSync2;
                    nxt_r.initCnt    = '0;
                    nxt_r.phase      = bss_pkg::PH_INIT;
                end else begin
                    nxt_r.syncCnt = r_ff.syncCnt + 2'h1;
                end
            end
            bss_pkg::PH_INIT: begin
                // Buffer stays off until the whole initialization count has run
                if (r_ff.initCnt == INIT_LAST) begin
                    nxt_r.phase  = r_ff.bootload ? bss_pkg::PH_BOOT
                                                 : bss_pkg::PH_RUN;
                    nxt_r.usbEnN = 1'b0;
                    evt[bss_pkg::IRQ_INIT] = 1'b1;
                end else begin
                    nxt_r.initCnt = r_ff.initCnt + 1'b1;
                end
            end
            bss_pkg::PH_RUN: begin
                // Held until next reset
                nxt_r.phase = bss_pkg::PH_RUN;
            end
            bss_pkg::PH_BOOT: begin
                // Held until next reset
                nxt_r.phase = bss_pkg::PH_BOOT;
            end
        endcase

        // Bootload mode counts as running
        running = (r_ff.phase == bss_pkg::PH_RUN) || (r_ff.phase == bss_pkg::PH_BOOT);
        oper    = running && !r_ff.ctrl[bss_pkg::CTRL_HALT];

        // Free-running half-second timebase shared by liveness and fault blinking
        // Never stops, even while halted
        aliveWrap = (r_ff.aliveCnt == ALIVE_LAST);
        nxt_r.aliveCnt = aliveWrap ? '0 : r_ff.aliveCnt + 1'b1;

        // Liveness pin only moves while operational; a frozen pin marks a halt
        if (oper && aliveWrap) begin
            nxt_r.alive = ~r_ff.alive;
        end else begin
            nxt_r.alive = r_ff.alive;
        end

        // Sequencer loopback: drive a pulse out and expect it back on the irq input
        for (int i = 0; i < 2; i++) begin
            if (seqRise[i]) begin
                evt[bss_pkg::IRQ_SEQ + i] = 1'b1;
            end
            // Count down to zero
            if (r_ff.pulseCnt[i] != 4'h0) begin
                nxt_r.pulseCnt[i] = r_ff.pulseCnt[i] - 4'h1;
            end
            // Return edge ends the wait
            if (seqRise[i]) begin
                nxt_r.loopWait[i] = 1'b0;
            end else if (r_ff.loopWait[i]) begin
                // A pulse that never returns points at a broken board link
                if (r_ff.loopCnt[i] == bss_pkg::LOOP_LAST) begin
                    nxt_r.loopWait[i] = 1'b0;
                    evt[bss_pkg::IRQ_LOOP + i] = 1'b1;
                end else begin
                    nxt_r.loopCnt[i] = r_ff.loopCnt[i] + 8'h01;
                end
            end
        end

        // Register writes
        if (regWr) begin
            unique case (regAddr)
                // Acts next cycle
                bss_pkg::REG_CTRL: begin
                    nxt_r.ctrl = regWdata[3:0];
                end
                bss_pkg::REG_PULSE: begin
                    // Pulses start only once running and never overlap a pending one
                    for (int i = 0; i < 2; i++) begin
                        if (regWdata[i] && running && (r_ff.pulseCnt[i] == 4'h0) && !r_ff.loopWait[i]) begin
                            nxt_r.pulseCnt[i] = bss_pkg::AUX_PULSE_LEN;
                            nxt_r.loopWait[i] = 1'b1;
                            nxt_r.loopCnt[i]  = 8'h00;
                        end
                    end
                end
                // Ones clear, zeros keep
                bss_pkg::REG_IRQ_STAT: begin
                    clr = regWdata[4:0];
                end
                bss_pkg::REG_IRQ_MASK: begin
                    nxt_r.irqMask = regWdata[4:0];
                end
                // Others ignore writes
                default: begin
                    nxt_r.ctrl = r_ff.ctrl;
                end
            endcase
        end

        // Sticky status: a new event beats a clear landing in the same cycle
        nxt_r.irqStat = (r_ff.irqStat & ~clr) | evt;

        // Aux outputs follow the pulse counters
        // Pin rises right after the write
        for (int i = 0; i < 2; i++) begin
            nxt_r.auxOut[i] = (nxt_r.pulseCnt[i] != 4'h0);
        end

        // Fault: software force or a lost loopback pulse, shown per the chosen style
        // Hold style wins over blinking
        faultOn = r_ff.ctrl[bss_pkg::CTRL_FFORCE]
                | r_ff.irqStat[bss_pkg::IRQ_LOOP]
                | r_ff.irqStat[bss_pkg::IRQ_LOOP + 1];
        if (!faultOn) begin
            nxt_r.fault = 1'b0;
        end else if (r_ff.ctrl[bss_pkg::CTRL_FHOLD]) begin
            nxt_r.fault = 1'b1;
        end else if (aliveWrap) begin
            nxt_r.fault = ~r_ff.fault;
        end

        // Register reads: data appear one cycle later and only then
        nxt_r.rdata = 32'h0000_0000;
        if (regRd) begin
            unique case (regAddr)
                bss_pkg::REG_CTRL: begin
                    nxt_r.rdata[3:0] = r_ff.ctrl;
                end
                // Live levels, not latched
                bss_pkg::REG_STATE: begin
                    nxt_r.rdata[bss_pkg::ST_BOOTLOAD] = r_ff.bootload;
                    nxt_r.rdata[bss_pkg::ST_INITDONE] = running;
                    nxt_r.rdata[bss_pkg::ST_OPER]     = oper;
                    nxt_r.rdata[bss_pkg::ST_FAULT]    = faultOn;
                    nxt_r.rdata[bss_pkg::ST_STRAP]    = r_ff.strapLevel;
                    nxt_r.rdata[bss_pkg::ST_WAIT +: 2] = r_ff.loopWait;
                end
                bss_pkg::REG_IRQ_STAT: begin
                    nxt_r.rdata[4:0] = r_ff.irqStat;
                end
                bss_pkg::REG_IRQ_MASK: begin
                    nxt_r.rdata[4:0] = r_ff.irqMask;
                end
                // Others read zero
                default: begin
                    nxt_r.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Level interrupt from the next status and mask, registered with them
        // Moves with its status bit
        nxt_r.irqOut = |(nxt_r.irqStat & nxt_r.irqMask);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Synchronous reset; the strap is caught later by the sample phase
    // Strap must hold until taken
    always_ff @(posedge clk) begin
        if (!rstn) begin
            r_ff <= RESET_VAL;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    // Bus answer and irq lag one cycle
    assign usb_buffer_enable_n = r_ff.usbEnN;
    assign fault_status        = r_ff.fault;
    assign alive_toggle        = r_ff.alive;
    assign sequencer_aux_out_a = r_ff.auxOut[0];  // Board ties this to irq input A
    assign sequencer_aux_out_b = r_ff.auxOut[1];  // Board ties this to irq input B
    assign split_config_out    = r_ff.ctrl[bss_pkg::CTRL_SPLIT];
    assign bootload_mode       = r_ff.bootload;
    assign regRdata            = r_ff.rdata;
    assign irq                 = r_ff.irqOut;

endmodule : bss_boot_status

// *** tb/bss_board_model.sv ***
/*
 * Board model: boot strap with pull-up and the aux to irq loop traces.
 * Assumes the bench picks the strap level and may cut loop A.
 */
`timescale 1ns/1ps

module bss_board_model (
    input  wire logic auxA,
    input  wire logic auxB,
    input  wire logic strapLow,
    input  wire logic cutA,
    output logic      irqA,
    output logic      irqB,
    output logic      strapN
);
    // Strap is pulled up unless a jumper grounds it
    assign strapN = strapLow ? 1'b0 : 1'b1;
    // Loop traces; a cut trace is held low by a board pull-down
    assign irqA   = cutA ? 1'b0 : auxA;
    assign irqB   = auxB;
endmodule : bss_board_model

// *** tb/bss_boot_status_sva.sv ***
/*
 * Port checker of the boot and status block.
 * Assumes the board loops each aux output straight to its irq input.
 */
`timescale 1ns/1ps

module bss_boot_status_sva #(
    parameter int unsigned INIT_CYCLES = 8,
    parameter int unsigned ALIVE_HALF  = 16
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        boot_select_n,
    input wire logic        sequencer_irq_in_a,
    input wire logic        sequencer_irq_in_b,
    input wire logic        usb_buffer_enable_n,
    input wire logic        fault_status,
    input wire logic        alive_toggle,
    input wire logic        sequencer_aux_out_a,
    input wire logic        sequencer_aux_out_b,
    input wire logic        split_config_out,
    input wire logic        bootload_mode,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr
);
    logic [15:0] sinceRel_ff;
    logic [31:0] stay_ff;
    logic        last_ff;
    logic        flip_ff;
    logic        halt_ff;
    logic        cause_ff;
    logic [3:0]  runA_ff;
    logic [3:0]  runB_ff;
    logic        ctrlWr;
    logic        flip;
    assign ctrlWr = regWr && regAddr == bss_pkg::REG_CTRL;
    assign flip   = alive_toggle != last_ff;
    // Edges since release, run length of the liveness level, seen fault causes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sinceRel_ff <= 16'h0000;
            stay_ff     <= 32'h0;
            last_ff     <= 1'b0;
            flip_ff     <= 1'b0;
            halt_ff     <= 1'b0;
            cause_ff    <= 1'b0;
            runA_ff     <= 4'h0;
            runB_ff     <= 4'h0;
        end else begin
            sinceRel_ff <= (sinceRel_ff == 16'hFFFF) ? sinceRel_ff : sinceRel_ff + 16'h0001;
            stay_ff     <= flip ? 32'h0 : stay_ff + 32'h1;
            last_ff     <= alive_toggle;
            flip_ff     <= flip_ff | flip;
            halt_ff     <= ctrlWr ? regWdata[1] : halt_ff;
            runA_ff     <= sequencer_aux_out_a ? runA_ff + 4'h1 : 4'h0;
            runB_ff     <= sequencer_aux_out_b ? runB_ff + 4'h1 : 4'h0;
            // A cut loop shows as aux high with its irq input low
            cause_ff    <= cause_ff | (sequencer_aux_out_a & ~sequencer_irq_in_a)
                         | (sequencer_aux_out_b & ~sequencer_irq_in_b) | (ctrlWr & regWdata[3]);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Pulse shape: high at the start, low once the run counter holds the full length
    sequence seq_body_a;
        sequencer_aux_out_a ##10 (!sequencer_aux_out_a && runA_ff == bss_pkg::AUX_PULSE_LEN);
    endsequence
    sequence seq_body_b;
        sequencer_aux_out_b ##10 (!sequencer_aux_out_b && runB_ff == bss_pkg::AUX_PULSE_LEN);
    endsequence
    a_usb_after_init: assert property (usb_buffer_enable_n == (sinceRel_ff < INIT_CYCLES + 3))
        else $error("usb buffer enable at wrong time");
    a_split_at_reset: assert property ($rose(rstn) |-> split_config_out)
        else $error("split config low after reset");
    a_boot_mode_pick: assert property (sinceRel_ff == 16'h0005 |-> bootload_mode == !boot_select_n)
        else $error("boot mode does not follow strap");
    a_boot_mode_kept: assert property (sinceRel_ff > 16'h0005 |-> $stable(bootload_mode))
        else $error("boot mode changed after sampling");
    a_fault_no_cause: assert property (!cause_ff |-> !fault_status)
        else $error("fault shown without a cause");
    a_fault_hold_on: assert property (ctrlWr && regWdata[3:2] == 2'b11 |-> ##[1:2] fault_status)
        else $error("held fault not shown");
    a_alive_period: assert property (flip && flip_ff |-> (stay_ff + 32'h1) % ALIVE_HALF == 0)
        else $error("liveness toggle period wrong");
    a_alive_frozen: assert property (usb_buffer_enable_n || (halt_ff && $past(halt_ff)) |-> $stable(alive_toggle))
        else $error("liveness moved while not operational");
    a_aux_pulse_a: assert property ($rose(sequencer_aux_out_a) |-> $past(regWr && regAddr == bss_pkg::REG_PULSE
        && regWdata[0]) ##0 seq_body_a)
        else $error("aux pulse a wrong");
    a_aux_pulse_b: assert property ($rose(sequencer_aux_out_b) |-> $past(regWr && regAddr == bss_pkg::REG_PULSE
        && regWdata[1]) ##0 seq_body_b)
        else $error("aux pulse b wrong");
endmodule : bss_boot_status_sva

bind bss_boot_status bss_boot_status_sva #(.INIT_CYCLES(INIT_CYCLES), .ALIVE_HALF(ALIVE_HALF)) i_sva (
    .clk(clk), .rstn(rstn), .boot_select_n(boot_select_n), .sequencer_irq_in_a(sequencer_irq_in_a),
    .sequencer_irq_in_b(sequencer_irq_in_b), .usb_buffer_enable_n(usb_buffer_enable_n),
    .fault_status(fault_status), .alive_toggle(alive_toggle), .sequencer_aux_out_a(sequencer_aux_out_a),
    .sequencer_aux_out_b(sequencer_aux_out_b), .split_config_out(split_config_out),
    .bootload_mode(bootload_mode), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr));

// *** tb/bss_boot_status_tb.sv ***
/*
 * Self-checking bench of the boot and status block with its board model.
 * Assumes short init and liveness counts handed to the instance.
 */
`timescale 1ns/1ps

module bss_boot_status_tb;
    localparam int unsigned HALF = 16;
    logic        clk = 1'b0, rstn = 1'b0, strapLow = 1'b0, cutA = 1'b0;
    logic        bootN, irqA, irqB, usbN, fault, alive, auxA, auxB, split, bootMode, irq, f;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata, d;
    logic        regWr = 1'b0, regRd = 1'b0;
    int          errCount = 0, numChecks = 0, n;
    logic [1:0]  rows [2] = '{2'b11, 2'b00}; // Strap low, expected bootload
    always #10 clk = ~clk;
    bss_board_model i_board (.auxA(auxA), .auxB(auxB), .strapLow(strapLow), .cutA(cutA),
        .irqA(irqA), .irqB(irqB), .strapN(bootN));
    bss_boot_status #(.INIT_CYCLES(8), .ALIVE_HALF(HALF)) i_dut (.clk(clk), .rstn(rstn),
        .boot_select_n(bootN), .sequencer_irq_in_a(irqA), .sequencer_irq_in_b(irqB),
        .usb_buffer_enable_n(usbN), .fault_status(fault), .alive_toggle(alive),
        .sequencer_aux_out_a(auxA), .sequencer_aux_out_b(auxB), .split_config_out(split),
        .bootload_mode(bootMode), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .irq(irq));
    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= v;
        @(posedge clk);
        regWr    <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe is taken
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd   <= 1'b0;
        @(posedge clk);
        d = regRdata;
    endtask : rd
    task automatic rst(input logic s);
        @(posedge clk);
        rstn     <= 1'b0;
        strapLow <= s;
        cyc(3);
        rstn     <= 1'b1;
    endtask : rst
    // Edges until the liveness level next moves, bounded
    task automatic nextFlip();
        logic a;
        a = alive;
        n = 0;
        while (alive === a && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask : nextFlip
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : giveVerdict
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        foreach (rows[i]) begin
            rst(rows[i][1]);
            cyc(6);
            chk(bootMode, rows[i][0]);
            chk(usbN, 1'b1);
            chk(split, 1'b1);
            for (n = 0; n < 60 && usbN !== 1'b0; n++) @(posedge clk);
            chk(usbN, 1'b0);
            rd(bss_pkg::REG_STATE);
            chk(d[0], rows[i][0]);
            $display("row %0d done", i);
        end
        strapLow <= 1'b1;
        cyc(5);
        chk(bootMode, 1'b0);
        strapLow <= 1'b0;
        nextFlip();
        nextFlip();
        chk(n, HALF);
        wr(bss_pkg::REG_CTRL, 32'h3);
        cyc(2);
        f = alive;
        cyc(3 * HALF);
        chk(alive, f);
        wr(bss_pkg::REG_CTRL, 32'h0);
        cyc(1);
        chk(split, 1'b0);
        wr(bss_pkg::REG_CTRL, 32'h1);
        $display("liveness and split done");
        // Loopback with the interrupt unmasked, masked and cleared
        wr(bss_pkg::REG_IRQ_STAT, 32'h1F);
        wr(bss_pkg::REG_IRQ_MASK, 32'h3);
        wr(bss_pkg::REG_PULSE, 32'h3);
        cyc(1);
        chk({auxA, auxB}, 2'b11);
        cyc(8);
        chk(irq, 1'b1);
        rd(bss_pkg::REG_IRQ_STAT);
        chk(d, 32'h3);
        wr(bss_pkg::REG_IRQ_MASK, 32'h0);
        cyc(2);
        chk(irq, 1'b0);
        wr(bss_pkg::REG_IRQ_MASK, 32'h3);
        cyc(2);
        chk(irq, 1'b1);
        wr(bss_pkg::REG_IRQ_STAT, 32'h3);
        cyc(2);
        chk(irq, 1'b0);
        $display("loopback done");
        // Lost loop return gives a toggled fault, then a software-forced held one
        cutA <= 1'b1;
        wr(bss_pkg::REG_PULSE, 32'h1);
        cyc(60);
        rd(bss_pkg::REG_IRQ_STAT);
        chk(d, 32'h4);
        f = 1'b0;
        repeat (2 * HALF + 4) begin
            @(posedge clk);
            f = f | fault;
        end
        chk(f, 1'b1);
        cutA <= 1'b0;
        wr(bss_pkg::REG_IRQ_STAT, 32'h4);
        cyc(3);
        chk(fault, 1'b0);
        wr(bss_pkg::REG_CTRL, 32'hD);
        cyc(2 + HALF);
        chk(fault, 1'b1);
        wr(bss_pkg::REG_CTRL, 32'h1);
        cyc(3);
        chk(fault, 1'b0);
        rd(8'h20);
        chk(d, 32'h0);
        $display("fault done");
        giveVerdict();
    end
    // Watchdog well past the expected run of under a thousand cycles
    initial begin
        #200_000;
        errCount++;
        giveVerdict();
    end
endmodule : bss_boot_status_tb
